// ---- include/lbus_pkg.sv ----
// constants for the local bus controller and clock generator
package lbus_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int MIN_CLOCKS = 4;
    localparam logic [1:0] ST_IDLE = 2'h0;
    localparam logic [1:0] ST_READ = 2'h1;
    localparam logic [1:0] ST_WRITE = 2'h2;
    localparam logic [1:0] ST_HOLD = 2'h3;
    localparam logic [1:0] PM_RUN = 2'h0;
    localparam logic [1:0] PM_IDLE = 2'h1;
    localparam logic [1:0] PM_DOWN = 2'h2;
endpackage

// ---- rtl/lbus_ctrl.sv ----
// local bus controller with divide-by-two processor clock generator
`timescale 1ns/1ps

// Operation
// - drive address, strobes, status, write data
// - capture read data from bus
// - cycle lasts four clocks, ready extends
// - yield bus on hold, answer grant
// - drive transceiver enable and direction
// - processor clock is input divided by two
// - clock output has 50% duty
// - bus timing referenced to clock output
// - powerdown stops all clocks, state held
// - idle stops core, peripherals keep running
module lbus_ctrl #(
    parameter int ADDR_W = lbus_pkg::ADDR_W,
    parameter int DATA_W = lbus_pkg::DATA_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [1:0] pm_mode,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_valid,
    input wire logic ready_pin,
    input wire logic hold_pin,
    output logic bus_grant_out,
    output logic [ADDR_W-1:0] ad_out,
    input wire logic [DATA_W-1:0] ad_in,
    output logic ad_oe_n,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [1:0] status,
    output logic transceiver_enable_n,
    output logic transceiver_direction,
    output logic processor_clock_output,
    output logic core_clk_en,
    output logic periph_clk_en
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_T1 = 4'h2,
        S_TX = 4'h4,
        S_HOLD = 4'h8
    } bus_state_e;

    bus_state_e state_q;
    logic [2:0] tcnt_q;
    logic ph_q;
    logic rdy_s1_q, rdy_s2_q, hld_s1_q, hld_s2_q;
    logic wr_q;
    logic [DATA_W-1:0] wdata_q;
    logic tick;
    logic run;

    // -------------------------------------------------
    // clock generation and power modes
    // -------------------------------------------------
    // powerdown freezes every flop except the clock enables, which clear; static design keeps state
    assign run = clk_en && (pm_mode != lbus_pkg::PM_DOWN);
    // bus work advances only on the rising-to-falling phase edge
    assign tick = run && ph_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ph_q <= 1'b0;
            processor_clock_output <= 1'b0;
        end else if (run) begin
            ph_q <= ~ph_q;
            processor_clock_output <= ~ph_q;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            core_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
        end else if (clk_en) begin
            core_clk_en <= run && ph_q && (pm_mode == lbus_pkg::PM_RUN);
            periph_clk_en <= run && ph_q;
        end
    end

    // -------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            hld_s1_q <= 1'b0;
            hld_s2_q <= 1'b0;
        end else if (run) begin
            rdy_s1_q <= ready_pin;
            rdy_s2_q <= rdy_s1_q;
            hld_s1_q <= hold_pin;
            hld_s2_q <= hld_s1_q;
        end
    end

    // -------------------------------------------------
    // bus cycle sequencer
    // -------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            tcnt_q <= 3'h0;
            wr_q <= 1'b0;
            wdata_q <= '0;
            ad_out <= '0;
            ad_oe_n <= 1'b1;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            status <= lbus_pkg::ST_IDLE;
            transceiver_enable_n <= 1'b1;
            transceiver_direction <= 1'b1;
            bus_grant_out <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else if (tick) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            ale <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (hld_s2_q) begin
                        state_q <= S_HOLD;
                        bus_grant_out <= 1'b1;
                        ad_oe_n <= 1'b1;
                        status <= lbus_pkg::ST_HOLD;
                    end else if (req_valid) begin
                        state_q <= S_T1;
                        tcnt_q <= 3'h1;
                        wr_q <= req_write;
                        wdata_q <= req_wdata;
                        req_ready <= 1'b1;
                        ad_out <= req_addr;
                        ad_oe_n <= 1'b0;
                        ale <= 1'b1;
                        status <= req_write ? lbus_pkg::ST_WRITE : lbus_pkg::ST_READ;
                        transceiver_direction <= req_write;
                    end
                end
                S_T1: begin
                    state_q <= S_TX;
                    tcnt_q <= 3'h2;
                    transceiver_enable_n <= 1'b0;
                    if (wr_q) begin
                        ad_out <= {{(ADDR_W-DATA_W){1'b0}}, wdata_q};
                        wr_n <= 1'b0;
                    end else begin
                        ad_oe_n <= 1'b1;
                        rd_n <= 1'b0;
                    end
                end
                S_TX: begin
                    if (tcnt_q < 3'(lbus_pkg::MIN_CLOCKS - 1)) begin
                        tcnt_q <= tcnt_q + 3'h1;
                    end else if (rdy_s2_q) begin
                        // last state: strobes drop, data taken
                        if (!wr_q) begin
                            rsp_rdata <= ad_in;
                            rsp_valid <= 1'b1;
                        end
                        state_q <= S_IDLE;
                        tcnt_q <= 3'h0;
                        rd_n <= 1'b1;
                        wr_n <= 1'b1;
                        ad_oe_n <= 1'b1;
                        transceiver_enable_n <= 1'b1;
                        transceiver_direction <= 1'b1;
                        status <= lbus_pkg::ST_IDLE;
                    end
                    // otherwise a wait state repeats
                end
                S_HOLD: begin
                    if (!hld_s2_q) begin
                        state_q <= S_IDLE;
                        bus_grant_out <= 1'b0;
                        status <= lbus_pkg::ST_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // -------------------------------------------------
    // checks
    // -------------------------------------------------
    AST_GRANT_QUIET: assert property (@(posedge sys_clk) disable iff (!nrst)
        bus_grant_out |-> (ad_oe_n && rd_n && wr_n))
        else $error("bus driven while granted");
    AST_DUTY: assert property (@(posedge sys_clk) disable iff (!nrst)
        run |=> (processor_clock_output != $past(processor_clock_output)))
        else $error("clock output did not toggle");
    AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!nrst)
        !clk_en |=> $stable(state_q) && $stable(processor_clock_output))
        else $error("state moved while frozen");
    AST_CORE_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && pm_mode == lbus_pkg::PM_IDLE) |=> !core_clk_en)
        else $error("core clock ran in idle");
    AST_NO_RDY_WAIT: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tick && state_q == S_TX && tcnt_q == 3'h3 && !rdy_s2_q) |=> state_q == S_TX)
        else $error("cycle ended without ready");
    AST_STROBE_DIR: assert property (@(posedge sys_clk) disable iff (!nrst)
        !rd_n |-> (!transceiver_direction && !transceiver_enable_n))
        else $error("transceiver wrong during read");
    AST_EDGE_REF: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!ph_q && !$past(ph_q)) |-> $stable(rd_n))
        else $error("strobe moved off clock edge");
    sequence s_start;
        tick && state_q == S_IDLE && req_valid && !hld_s2_q;
    endsequence
    AST_MIN_LEN: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_start |=> (state_q != S_IDLE) [*6])
        else $error("bus cycle shorter than minimum");
endmodule

// ---- verification/mem_model.sv ----
// external memory model answering local bus cycles
`timescale 1ns/1ps
module mem_model (
    input wire logic sys_clk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [19:0] ad_out,
    input wire logic [3:0] waits,
    output logic [15:0] ad_in,
    output logic ready_pin,
    output logic [15:0] wdata_q
);
    logic [19:0] addr_q = 20'h0;
    logic [15:0] last_q = 16'h0;
    logic [3:0] cnt_q = 4'hf;
    // a released bus shows the inverse of the last value, never a stale copy
    assign ad_in = !rd_n ? addr_q[15:0] ^ 16'h5a5a : ~last_q;
    assign ready_pin = cnt_q >= waits;
    always_ff @(posedge sys_clk) begin
        if (ale) begin
            addr_q <= ad_out;
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (!rd_n) last_q <= ad_in;
        if (!wr_n) wdata_q <= ad_out[15:0];
    end
endmodule

// ---- verification/test_lbus_ctrl.sv ----
// self-checking bench for the local bus controller
`timescale 1ns/1ps
module test_lbus_ctrl;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] pm_mode = lbus_pkg::PM_RUN;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [19:0] req_addr = 20'h0;
    logic [15:0] req_wdata = 16'h0;
    logic hold_pin = 1'b0;
    logic [3:0] waits = 4'h0;
    logic req_ready, rsp_valid, ready_pin, bus_grant_out, ad_oe_n, ale, rd_n, wr_n;
    logic trx_en_n, trx_dir, pclk, core_en, per_en;
    logic [15:0] rsp_rdata, ad_in, wdata_q;
    logic [19:0] ad_out;
    logic [1:0] status;
    int n_mismatch = 0;
    int checks = 0;
    int run = 0;
    int last_len = 0;
    int plain = 0;
    int cyc = 0;
    always #2.5 sys_clk = ~sys_clk;
    lbus_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .pm_mode(pm_mode),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
        .rsp_valid(rsp_valid), .ready_pin(ready_pin), .hold_pin(hold_pin),
        .bus_grant_out(bus_grant_out), .ad_out(ad_out), .ad_in(ad_in), .ad_oe_n(ad_oe_n),
        .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .status(status),
        .transceiver_enable_n(trx_en_n), .transceiver_direction(trx_dir),
        .processor_clock_output(pclk), .core_clk_en(core_en), .periph_clk_en(per_en));
    mem_model mem_u (.sys_clk(sys_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .ad_out(ad_out), .waits(waits), .ad_in(ad_in), .ready_pin(ready_pin),
        .wdata_q(wdata_q));
    // ----------------------------------------
    // checking, timeout and closing report
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // status shows a transfer from T1 to T3 only; T4 is idle bus time before the next cycle
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
        if (status == lbus_pkg::ST_READ || status == lbus_pkg::ST_WRITE) run++;
        else if (run != 0) begin
            last_len = run;
            run = 0;
        end
    end
    task automatic bus_op(input logic wr, input logic [19:0] a, input logic [15:0] d);
        int n;
        int got;
        n = 0;
        got = 0;
        {req_write, req_addr, req_wdata, req_valid} = {wr, a, d, 1'b1};
        while (req_ready !== 1'b1 && n < 60) begin
            @(posedge sys_clk) #1;
            n++;
        end
        req_valid = 1'b0;
        do begin
            @(posedge sys_clk) #1;
            n++;
            if (ale === 1'b1) check("address", ad_out, a);
            if (rd_n === 1'b0) check("rx ctl", {trx_en_n, trx_dir}, 2'b00);
            if (wr_n === 1'b0) check("tx ctl", {trx_en_n, trx_dir}, 2'b01);
            if (rsp_valid === 1'b1) got++;
            if (rsp_valid === 1'b1) check("rdata", rsp_rdata, a[15:0] ^ 16'h5a5a);
        end while ((status !== lbus_pkg::ST_IDLE || (!wr && got == 0)) && n < 200);
        check("response", got, !wr);
        repeat (2) @(posedge sys_clk) #1;
        check("status span", last_len >= 2 * (lbus_pkg::MIN_CLOCKS - 1), 1);
        if (wr) check("wdata", wdata_q, d);
    endtask
    task automatic measure(input int hi, input int tog, input int core, input int per);
        int h, t, c, p;
        logic prev;
        h = 0;
        t = 0;
        c = 0;
        p = 0;
        repeat (4) @(posedge sys_clk) #1;
        prev = pclk;
        repeat (20) begin
            @(posedge sys_clk) #1;
            h += (pclk === 1'b1);
            t += (pclk !== prev);
            c += (core_en === 1'b1);
            p += (per_en === 1'b1);
            prev = pclk;
        end
        if (hi >= 0) check("clock high", h, hi);
        check("clock toggles", t, tog);
        check("core ticks", c, core);
        check("periph ticks", p, per);
    endtask
    task automatic hold_test;
        int n;
        n = 0;
        hold_pin = 1'b1;
        while (bus_grant_out !== 1'b1 && n < 40) begin
            @(posedge sys_clk) #1;
            n++;
        end
        check("bus yielded", {ad_oe_n, rd_n, wr_n, status}, {3'b111, lbus_pkg::ST_HOLD});
        req_valid = 1'b1;
        n = 0;
        repeat (10) begin
            @(posedge sys_clk) #1;
            n += (req_ready === 1'b1);
        end
        check("taken in hold", n, 0);
        hold_pin = 1'b0;
        bus_op(1'b0, 20'h0a5c3, 16'h0);
    endtask
    // back-to-back reads: the spacing of address latches is the full cycle, T4 included
    task automatic pair_test;
        int n;
        int first;
        logic prev;
        n = 0;
        first = -1;
        prev = 1'b0;
        req_write = 1'b0;
        req_addr = 20'h01230;
        req_valid = 1'b1;
        while (n < 60) begin
            @(posedge sys_clk) #1;
            n++;
            if (req_ready === 1'b1) req_addr = 20'h04560;
            if (ale === 1'b1 && prev !== 1'b1) begin
                if (first >= 0) break;
                first = n;
            end
            prev = ale;
        end
        req_valid = 1'b0;
        check("cycle length", n - first, 2 * lbus_pkg::MIN_CLOCKS);
        check("second address", ad_out, 20'h04560);
        repeat (12) @(posedge sys_clk) #1;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 nrst = 1'b1;
        measure(10, 20, 10, 10);
        bus_op(1'b0, 20'hf1234, 16'h0);
        plain = last_len;
        bus_op(1'b1, 20'h00abc, 16'hbeef);
        pair_test();
        waits = 4'hc;
        bus_op(1'b0, 20'h0ff00, 16'h0);
        check("wait stretch", last_len > plain, 1);
        waits = 4'h0;
        hold_test();
        pm_mode = lbus_pkg::PM_IDLE;
        measure(10, 20, 0, 10);
        pm_mode = lbus_pkg::PM_DOWN;
        measure(-1, 0, 0, 0);
        pm_mode = lbus_pkg::PM_RUN;
        clk_en = 1'b0;
        measure(-1, 0, 0, 0);
        clk_en = 1'b1;
        measure(10, 20, 10, 10);
        bus_op(1'b0, 20'h15555, 16'h0);
        test_done();
    end
endmodule
